// ===== sgpe_pkg.sv
// shared constants for the standby general-purpose port: register offsets,
// field positions, reset values, read-path codes and debounce timing.
// assumes a 100 MHz ref_clk and an 8-bit register port with a bank select.
package sgpe_pkg;

  // port geometry
  localparam int PIN_COUNT = 8; // pins in the port
  localparam int BIDIR_COUNT = 6; // pins 0-5 can drive
  localparam int SETUP_W = 7; // stored setup bits per pin (6:0)
  localparam int PIN_NUM_W = 3; // pin number field width

  // register offsets and bank of the pin setup pair
  localparam logic [4:0] OFF_OUTPUT_VALUE = 5'h08; // runtime data out
  localparam logic [4:0] OFF_INPUT_LEVEL = 5'h09; // runtime data in
  localparam logic [4:0] OFF_PIN_INDEX = 5'h13; // pin select index
  localparam logic [4:0] OFF_PIN_SETUP = 5'h14; // setup of indexed pin
  localparam logic [1:0] BANK_PIN_SETUP = 2'h3; // bank holding index/setup

  // reset values and writable masks
  localparam logic [7:0] OUTPUT_VALUE_RST = 8'h3F; // data out after reset
  localparam logic [7:0] PIN_INDEX_RST = 8'h00; // index after reset
  localparam logic [7:0] PIN_INDEX_MASK = 8'h17; // port select and pin number
  localparam logic [6:0] PIN_SETUP_RST = 7'h44; // debounce and pull-up on
  localparam logic [3:0] PAD_FIELD_MASK = 4'hF; // bits 0-3 of a setup

  // setup field positions
  localparam int B_OUT_EN = 0; // drive enable
  localparam int B_PUSH_PULL = 1; // 1 push-pull, 0 open-drain
  localparam int B_PULL_UP = 2; // weak pull-up enable
  localparam int B_LOCK = 3; // set-only lock
  localparam int B_EV_LEVEL = 4; // 1 level, 0 edge
  localparam int B_EV_POL = 5; // 1 rising/high, 0 falling/low
  localparam int B_DEBOUNCE = 6; // debounce enable
  localparam int B_PORT_SEL = 4; // port select in the index

  // debounce time and its cycle count at the clock rate
  localparam int DEBOUNCE_TIME_MS = 15; // settle time in msec
  localparam int CLK_FREQ_KHZ = 100000; // ref_clk rate
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * CLK_FREQ_KHZ;

  // which register a pending read returns
  typedef enum logic [2:0] {
    RD_NONE = 3'b000,
    RD_OUTPUT = 3'b001,
    RD_INPUT = 3'b010,
    RD_INDEX = 3'b011,
    RD_SETUP = 3'b100
  } sgpe_read_t;

  // offset compare, with the bank checked only for banked offsets
  function automatic logic regHit(input logic [4:0] addr, input logic [1:0] bank,
                                  input logic [4:0] off, input logic banked);
    regHit = (addr == off) && (!banked || (bank == BANK_PIN_SETUP));
  endfunction

endpackage

// ===== sgpe_setup_store.sv
// per-pin setup storage: one word per pin, all words visible in parallel,
// one registered read port addressed by the current pin index.
// assumes the writer has already applied locking and field masking.
`timescale 1ns/1ns
module sgpe_setup_store
  import sgpe_pkg::*;
#(
  parameter int DEPTH = PIN_COUNT,
  parameter int WIDTH = SETUP_W,
  parameter int AW = PIN_NUM_W,
  parameter logic [SETUP_W-1:0] RESET_VALUE = PIN_SETUP_RST
)(
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // power-up reset, async high
  input wire logic wrEn, // store wrData at wrIndex
  input wire logic [AW-1:0] wrIndex, // word written
  input wire logic [WIDTH-1:0] wrData, // value written
  input wire logic [AW-1:0] rdIndex, // word read
  output logic [WIDTH-1:0] rdData, // registered read word
  output logic [DEPTH*WIDTH-1:0] setupAll // every word, flattened
);

  // refuse shapes the index cannot address
  if (DEPTH != (1 << AW) || WIDTH != SETUP_W) begin : g_bad_shape
    $error("setup store shape not supported");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // stored words
  logic [WIDTH-1:0] next_mem [DEPTH]; // next stored words
  logic [WIDTH-1:0] next_rdData; // next read word

  // next contents and read word
  always_comb
  begin
    next_mem = mem;
    if (wrEn)
    begin
      next_mem[wrIndex] = wrData;
    end
    next_rdData = mem[rdIndex];
  end

  // register storage; only power-up reset loads RESET_VALUE into it
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= RESET_VALUE;
      end
      rdData <= '0;
    end
    else
    begin
      mem <= next_mem;
      rdData <= next_rdData;
    end
  end

  // flatten for the pin logic
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      setupAll[i*WIDTH +: WIDTH] = mem[i];
    end
  end

endmodule // sgpe_setup_store

// ===== sgpe_debounce.sv
// one-pin debouncer: a new level passes only after it has held unchanged
// for CYCLES clocks; when disabled the level passes unfiltered on the next clock.
// assumes sampleIn is already synchronised to ref_clk.
`timescale 1ns/1ns
module sgpe_debounce #(
  parameter int CYCLES = 1500000,
  parameter logic RESET_LEVEL = 1'b1
)(
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic enable, // debounce on
  input wire logic sampleIn, // synchronised pin level
  output logic stableOut // level handed to the detector
);

  if (CYCLES < 1) begin : g_bad_count
    $error("debounce count must be at least one");
  end

  localparam int CW = $clog2(CYCLES + 1); // counter width

  logic [CW-1:0] count; // clocks the new level has held
  logic [CW-1:0] next_count; // next hold count
  logic next_stableOut; // next passed level

  // settle counter; any bounce restarts it
  always_comb
  begin
    next_count = count;
    next_stableOut = stableOut;
    if (!enable)
    begin
      next_stableOut = sampleIn;
      next_count = '0;
    end
    else if (sampleIn == stableOut)
    begin
      next_count = '0;
    end
    else if (count == CW'(CYCLES - 1))
    begin
      next_stableOut = sampleIn;
      next_count = '0;
    end
    else
    begin
      next_count = count + 1'b1;
    end
  end

  // register the counter and level
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count <= '0;
      stableOut <= RESET_LEVEL;
    end
    else
    begin
      count <= next_count;
      stableOut <= next_stableOut;
    end
  end

endmodule // sgpe_debounce

// ===== sgpe_gpio_port.sv
// standby general-purpose port: runtime data out/in registers, indexed
// per-pin setup, pad drive control and per-pin event detection.
// assumes register strobes and deviceActive come from ref_clk logic;
// pinLevel comes from pads and is synchronised here.
`timescale 1ns/1ns
module sgpe_gpio_port
  import sgpe_pkg::*;
#(
  parameter int DEBOUNCE_COUNT = DEBOUNCE_CYCLES
)(
  input wire logic ref_clk, // system clock, 100 MHz
  input wire logic sys_rst, // power-up reset, async high
  input wire logic swReset, // software reset pulse
  input wire logic deviceActive, // wake-up unit enabled
  input wire logic [1:0] regBank, // bank of banked offsets
  input wire logic [4:0] regAddr, // register offset
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  input wire logic [7:0] regWdata, // write data
  output logic [7:0] regRdata, // read data
  output logic regRdValid, // read data valid pulse
  input wire logic [PIN_COUNT-1:0] pinLevel, // pad input levels
  output logic [BIDIR_COUNT-1:0] padOut, // pad output level
  output logic [BIDIR_COUNT-1:0] padOe, // pad drive enable
  output logic [BIDIR_COUNT-1:0] padPullUp, // weak pull-up enable
  output logic [PIN_COUNT-1:0] pinEvent // event status to wake-up logic
);

  if (PIN_COUNT != 8 || BIDIR_COUNT > PIN_COUNT || DEBOUNCE_COUNT < 1)
  begin : g_bad_params
    $error("port shape or debounce count not supported");
  end

  // register decode
  logic hitOutput; // data out offset
  logic hitInput; // data in offset
  logic hitIndex; // index offset in setup bank
  logic hitSetup; // setup offset in setup bank

  assign hitOutput = regHit(regAddr, regBank, OFF_OUTPUT_VALUE, 1'b0);
  assign hitInput = regHit(regAddr, regBank, OFF_INPUT_LEVEL, 1'b0);
  assign hitIndex = regHit(regAddr, regBank, OFF_PIN_INDEX, 1'b1);
  assign hitSetup = regHit(regAddr, regBank, OFF_PIN_SETUP, 1'b1);

  // ---------- pin index ----------
  logic [7:0] pinIndex; // port select and pin number
  logic [7:0] next_pinIndex; // next index
  logic [PIN_NUM_W-1:0] selPin; // indexed pin
  logic setupReachable; // port 0 selected

  assign selPin = pinIndex[PIN_NUM_W-1:0];
  assign setupReachable = !pinIndex[B_PORT_SEL]; // port 1 is reserved

  // index update; only defined bits store
  always_comb
  begin
    next_pinIndex = pinIndex;
    if (swReset)
    begin
      next_pinIndex = PIN_INDEX_RST;
    end
    else if (regWr && hitIndex)
    begin
      next_pinIndex = regWdata & PIN_INDEX_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinIndex <= PIN_INDEX_RST;
    end
    else
    begin
      pinIndex <= next_pinIndex;
    end
  end

  // ---------- pin setup ----------
  logic [PIN_COUNT*SETUP_W-1:0] setupAll; // all pin setups
  logic [SETUP_W-1:0] setupRd; // indexed setup, registered
  logic [SETUP_W-1:0] setupOld; // indexed setup now
  logic [SETUP_W-1:0] setupNew; // value to store
  logic setupWr; // store strobe
  logic [PIN_COUNT-1:0] lockVec; // lock bit of each pin

  assign setupOld = setupAll[selPin*SETUP_W +: SETUP_W];
  assign setupWr = regWr && hitSetup && setupReachable;

  // merge a write with lock and pin-type limits
  always_comb
  begin
    setupNew = regWdata[SETUP_W-1:0]; // bit 7 dropped
    if (setupOld[B_LOCK])
    begin
      setupNew[3:0] = setupOld[3:0]; // locked fields hold
    end
    setupNew[B_LOCK] = setupNew[B_LOCK] | setupOld[B_LOCK];
    if (32'(selPin) >= BIDIR_COUNT)
    begin
      setupNew[3:0] = 4'h0; // input-only pins keep no pad fields
    end
  end

  sgpe_setup_store #(
    .DEPTH(PIN_COUNT),
    .WIDTH(SETUP_W),
    .AW(PIN_NUM_W),
    .RESET_VALUE(PIN_SETUP_RST)
  ) u_setup (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wrEn(setupWr),
    .wrIndex(selPin),
    .wrData(setupNew),
    .rdIndex(selPin),
    .rdData(setupRd),
    .setupAll(setupAll)
  );

  // collect lock bits for the data-out path
  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      lockVec[i] = setupAll[i*SETUP_W + B_LOCK];
    end
  end

  // ---------- data out ----------
  logic [BIDIR_COUNT-1:0] outValue; // stored data out
  logic [BIDIR_COUNT-1:0] next_outValue; // next data out
  logic [BIDIR_COUNT-1:0] freeBits; // unlocked bits

  assign freeBits = ~lockVec[BIDIR_COUNT-1:0];

  // writes and soft reset touch only unlocked bits
  always_comb
  begin
    next_outValue = outValue;
    if (swReset)
    begin
      next_outValue = (OUTPUT_VALUE_RST[BIDIR_COUNT-1:0] & freeBits)
                    | (outValue & ~freeBits);
    end
    else if (regWr && hitOutput && deviceActive) // blocked when inactive
    begin
      next_outValue = (regWdata[BIDIR_COUNT-1:0] & freeBits)
                    | (outValue & ~freeBits);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      outValue <= OUTPUT_VALUE_RST[BIDIR_COUNT-1:0];
    end
    else
    begin
      outValue <= next_outValue;
    end
  end

  // ---------- pad drive ----------
  logic [BIDIR_COUNT-1:0] next_padOut; // next pad level
  logic [BIDIR_COUNT-1:0] next_padOe; // next drive enable
  logic [BIDIR_COUNT-1:0] next_padPullUp; // next pull-up

  // open-drain drives only the low level
  always_comb
  begin
    for (int i = 0; i < BIDIR_COUNT; i++)
    begin
      next_padOut[i] = outValue[i];
      next_padOe[i] = setupAll[i*SETUP_W + B_OUT_EN]
                    & (setupAll[i*SETUP_W + B_PUSH_PULL] | ~outValue[i]);
      next_padPullUp[i] = setupAll[i*SETUP_W + B_PULL_UP];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      padOut <= '0;
      padOe <= '0;
      padPullUp <= '0;
    end
    else
    begin
      padOut <= next_padOut;
      padOe <= next_padOe;
      padPullUp <= next_padPullUp;
    end
  end

  // ---------- input sync ----------
  logic [PIN_COUNT-1:0] pinMeta; // first stage, read only by pinSync
  logic [PIN_COUNT-1:0] pinSync; // synchronised levels

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinMeta <= '1;
      pinSync <= '1;
    end
    else
    begin
      pinMeta <= pinLevel;
      pinSync <= pinMeta;
    end
  end

  // ---------- debounce and detection ----------
  logic [PIN_COUNT-1:0] pinStable; // level after debounce
  logic [PIN_COUNT-1:0] pinPrev; // previous detector level
  logic [PIN_COUNT-1:0] next_pinEvent; // next event status

  for (genvar g = 0; g < PIN_COUNT; g++)
  begin : g_pin
    sgpe_debounce #(
      .CYCLES(DEBOUNCE_COUNT),
      .RESET_LEVEL(1'b1)
    ) u_debounce (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .enable(setupAll[g*SETUP_W + B_DEBOUNCE]),
      .sampleIn(pinSync[g]),
      .stableOut(pinStable[g]) // delays both set and clear
    );
  end

  // edge gives a one-cycle pulse, level follows the pin
  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      if (setupAll[i*SETUP_W + B_EV_LEVEL])
      begin
        next_pinEvent[i] = pinStable[i] == setupAll[i*SETUP_W + B_EV_POL];
      end
      else if (setupAll[i*SETUP_W + B_EV_POL])
      begin
        next_pinEvent[i] = pinStable[i] & ~pinPrev[i]; // rising
      end
      else
      begin
        next_pinEvent[i] = ~pinStable[i] & pinPrev[i]; // falling
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinPrev <= '1;
      pinEvent <= '0;
    end
    else
    begin
      pinPrev <= pinStable;
      pinEvent <= next_pinEvent;
    end
  end

  // ---------- read path ----------
  sgpe_read_t rdSlot; // register a pending read returns
  sgpe_read_t next_rdSlot; // next pending read
  logic [7:0] next_regRdata; // next read data
  logic next_regRdValid; // next valid pulse
  logic rdPend; // a read strobe came last cycle

  // select on the strobe, answer two cycles later
  always_comb
  begin
    next_rdSlot = RD_NONE;
    if (regRd)
    begin
      if (hitOutput && deviceActive)
      begin
        next_rdSlot = RD_OUTPUT;
      end
      else if (hitInput && deviceActive)
      begin
        next_rdSlot = RD_INPUT;
      end
      else if (hitIndex)
      begin
        next_rdSlot = RD_INDEX;
      end
      else if (hitSetup && setupReachable)
      begin
        next_rdSlot = RD_SETUP;
      end
    end
    next_regRdValid = 1'b0;
    next_regRdata = regRdata;
    if (regRdValid)
    begin
      next_regRdata = '0;
    end
    if (rdPend)
    begin
      next_regRdValid = 1'b1;
      case (rdSlot)
        RD_OUTPUT: next_regRdata = 8'(outValue);
        RD_INPUT: next_regRdata = pinSync;
        RD_INDEX: next_regRdata = pinIndex;
        RD_SETUP: next_regRdata = {1'b0, setupRd};
        default: next_regRdata = '0; // unmapped or blocked
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdSlot <= RD_NONE;
      rdPend <= 1'b0;
      regRdata <= '0;
      regRdValid <= 1'b0;
    end
    else
    begin
      rdSlot <= next_rdSlot;
      rdPend <= regRd;
      regRdata <= next_regRdata;
      regRdValid <= next_regRdValid;
    end
  end

endmodule // sgpe_gpio_port

// ===== sgpe_chk.sv
// checker for the standby port: read answers, pad causes, reset pad state
// assumes it is bound to sgpe_gpio_port and sees only its ports
`timescale 1ns/1ns
module sgpe_chk
  import sgpe_pkg::*;
#(
  parameter int DEBOUNCE_COUNT = DEBOUNCE_CYCLES
)(
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // power-up reset
  input wire logic swReset, // software reset
  input wire logic deviceActive, // unit enabled
  input wire logic [1:0] regBank, // bank
  input wire logic [4:0] regAddr, // offset
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  input wire logic [7:0] regWdata, // write data
  input wire logic [7:0] regRdata, // read data
  input wire logic regRdValid, // read valid
  input wire logic [PIN_COUNT-1:0] pinLevel, // pad levels
  input wire logic [BIDIR_COUNT-1:0] padOut, // pad level
  input wire logic [BIDIR_COUNT-1:0] padOe, // pad enable
  input wire logic [BIDIR_COUNT-1:0] padPullUp, // pull-up
  input wire logic [PIN_COUNT-1:0] pinEvent // events
);
  logic [1:0] upCnt; // edges since reset, saturating
  logic [1:0] next_upCnt; // next count
  // count up to three so past values never reach into reset
  always_comb
    next_upCnt = (upCnt == 2'h3) ? upCnt : upCnt + 2'h1;
  // register the count
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      upCnt <= 2'h0;
    else
      upCnt <= next_upCnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_rdLatency;
    upCnt == 2'h3 |-> regRdValid == $past(regRd, 2);
  endproperty
  a_rdLatency: assert property (p_rdLatency)
    else $error("read answer late");
  property p_dataIdle;
    !regRdValid |-> regRdata == 8'h00;
  endproperty
  a_dataIdle: assert property (p_dataIdle)
    else $error("read data not zero outside answer");
  property p_inactiveRd;
    regRd && !deviceActive && (regAddr == OFF_OUTPUT_VALUE || regAddr == OFF_INPUT_LEVEL)
      |-> ##2 regRdValid && regRdata == 8'h00;
  endproperty
  a_inactiveRd: assert property (p_inactiveRd)
    else $error("runtime read answered while inactive");
  property p_unmapped;
    regRd && (regAddr < 5'h08 || (regAddr > 5'h09 && regAddr < 5'h13) || regAddr > 5'h14)
      |-> ##2 regRdValid && regRdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_idxRsv;
    regRd && regAddr == OFF_PIN_INDEX && regBank == BANK_PIN_SETUP
      |-> ##2 (regRdata & 8'hE8) == 8'h00;
  endproperty
  a_idxRsv: assert property (p_idxRsv)
    else $error("index reserved bits set");
  property p_padCause;
    upCnt == 2'h3 && $changed(padOut) |->
      ($past(regWr, 2) && $past(regAddr, 2) == OFF_OUTPUT_VALUE && $past(deviceActive, 2))
      || $past(swReset, 2);
  endproperty
  a_padCause: assert property (p_padCause)
    else $error("pad level changed unasked");
  property p_resetPads;
    $fell(sys_rst) |=> padOut == 6'h3F && padPullUp == 6'h3F && padOe == 6'h00;
  endproperty
  a_resetPads: assert property (p_resetPads)
    else $error("pads wrong after power-up");
  property p_outRead;
    (regRd && regAddr == OFF_OUTPUT_VALUE && deviceActive && !regWr && !swReset)
      ##1 (deviceActive && !regWr && !swReset) |=> regRdata == {2'b00, $past(padOut)};
  endproperty
  a_outRead: assert property (p_outRead)
    else $error("data-out read wrong");
  c_readData: cover property (regRdValid && regRdata != 8'h00);
  c_event: cover property (|pinEvent);
  c_padChange: cover property ($changed(padOut));
endmodule // sgpe_chk

bind sgpe_gpio_port sgpe_chk #(.DEBOUNCE_COUNT(DEBOUNCE_COUNT)) u_sgpe_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .swReset(swReset), .deviceActive(deviceActive),
  .regBank(regBank), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
  .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
  .pinLevel(pinLevel), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
  .pinEvent(pinEvent)
);

// ===== sgpe_pin_model.sv
// pin-side model: outside drivers, weak pull-ups and floating lines
// assumes pad controls from the port and drive commands from the bench
`timescale 1ns/1ns
module sgpe_pin_model (
  input wire logic ref_clk, // clock for the floating pattern
  input wire logic [5:0] padOut, // port drive level
  input wire logic [5:0] padOe, // port drive enable
  input wire logic [5:0] padPullUp, // weak pull-up enable
  input wire logic [7:0] extOe, // outside driver enable
  input wire logic [7:0] extVal, // outside driver level
  output logic [7:0] pinLevel // resolved levels
);
  logic flt = 1'b0; // undriven lines wander each cycle
  wire [7:0] drvOe = {2'b00, padOe}; // input-only pins never driven
  wire [7:0] drvVal = {2'b00, padOut}; // port levels widened
  wire [7:0] pullEn = {2'b00, padPullUp}; // no pull-up on input-only pins
  // toggle so a floating line never looks stable
  always @(posedge ref_clk)
    flt <= ~flt;
  // port driver first, then outside driver, then pull-up
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (drvOe[i])
        pinLevel[i] = drvVal[i];
      else if (extOe[i])
        pinLevel[i] = extVal[i];
      else if (pullEn[i])
        pinLevel[i] = 1'b1;
      else
        pinLevel[i] = flt;
    end
  end
endmodule // sgpe_pin_model

// ===== testbench.sv
// bench for the standby port: registers, pads, lock, resets and pin events
// assumes the port, the pin model and the bound checker compile alongside
`timescale 1ns/1ns
module testbench
  import sgpe_pkg::*;
;
  localparam int DB = 8; // short debounce for simulation
  logic ref_clk = 1'b0; // 100 MHz clock
  logic sys_rst = 1'b1; // power-up reset
  logic swReset = 1'b0; // software reset
  logic deviceActive = 1'b1; // unit enabled
  logic regWr = 1'b0; // write strobe
  logic regRd = 1'b0; // read strobe
  logic [1:0] regBank = 2'h3; // bank
  logic [4:0] regAddr = 5'h00; // offset
  logic [7:0] regWdata = 8'h00; // write data
  logic [7:0] extOe = 8'hC0; // outside drivers on pins 7-6
  logic [7:0] extVal = 8'h80; // outside levels
  logic [7:0] regRdata, pinLevel, pinEvent; // port answers and pin levels
  logic regRdValid; // read answer
  logic [5:0] padOut, padOe, padPullUp; // pad controls
  int err_total = 0; // mismatches
  int cmp_count = 0; // comparisons
  // clock generator
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  sgpe_gpio_port #(.DEBOUNCE_COUNT(DB)) u_sgpe_gpio_port (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .swReset(swReset), .deviceActive(deviceActive), .regBank(regBank),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata),
    .regRdata(regRdata), .regRdValid(regRdValid), .pinLevel(pinLevel), .padOut(padOut),
    .padOe(padOe), .padPullUp(padPullUp), .pinEvent(pinEvent));
  sgpe_pin_model u_sgpe_pin_model (.ref_clk(ref_clk), .padOut(padOut), .padOe(padOe),
    .padPullUp(padPullUp), .extOe(extOe), .extVal(extVal), .pinLevel(pinLevel));
  // verdict and end of run
  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // a wait that ran out
  task automatic timeout(input string what);
    err_total++;
    $display("[ERR] %s expected answer seen none", what);
    complete_run();
  endtask
  // compare one byte
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one register write
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  // one register read, judged against exp
  task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
    int n;
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    for (n = 0; n < 4 && regRdValid !== 1'b1; n++)
      @(negedge ref_clk);
    if (regRdValid !== 1'b1)
      timeout(what);
    chk(what, exp, regRdata);
  endtask
  // select a pin and write its setup
  task automatic setp(input logic [7:0] pin, input logic [7:0] cfg);
    wr(OFF_PIN_INDEX, pin);
    wr(OFF_PIN_SETUP, cfg);
  endtask
  // let a register change reach the pads
  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask
  // reset values of every register, pull-ups and drive enables
  task automatic t_reset();
    int i;
    rd(OFF_OUTPUT_VALUE, 8'h3F, "dataOut");
    rd(OFF_PIN_INDEX, 8'h00, "index");
    rd(OFF_INPUT_LEVEL, 8'hBF, "dataIn");
    chk("pullUp", 8'h3F, {2'b00, padPullUp});
    chk("padOe", 8'h00, {2'b00, padOe});
    for (i = 0; i < 8; i++)
    begin
      wr(OFF_PIN_INDEX, i[7:0]);
      rd(OFF_PIN_SETUP, 8'h44, "setup");
    end
  endtask
  // drive, buffer types, pull-up and input sampling
  task automatic t_drive();
    int i;
    for (i = 0; i < 6; i++)
      setp(i[7:0], 8'h47);
    wr(OFF_OUTPUT_VALUE, 8'h15);
    settle();
    chk("padOut", 8'h15, {2'b00, padOut});
    chk("padOe", 8'h3F, {2'b00, padOe});
    rd(OFF_INPUT_LEVEL, 8'h95, "dataIn");
    wr(OFF_INPUT_LEVEL, 8'hFF);
    rd(OFF_OUTPUT_VALUE, 8'h15, "dataOut");
    wr(OFF_OUTPUT_VALUE, 8'hFF);
    rd(OFF_OUTPUT_VALUE, 8'h3F, "dataOutRsv");
    setp(8'h00, 8'h45);
    settle();
    chk("openDrainHigh", 8'h3E, {2'b00, padOe});
    wr(OFF_OUTPUT_VALUE, 8'h3E);
    setp(8'h00, 8'h41);
    settle();
    chk("openDrainLow", 8'h3F, {2'b00, padOe});
    chk("pullUpOff", 8'h3E, {2'b00, padPullUp});
    setp(8'h02, 8'h44);
    @(posedge ref_clk);
    extOe <= 8'hC4;
    settle();
    rd(OFF_INPUT_LEVEL, 8'hBA, "dataInExt");
  endtask
  // runtime access blocked while the unit is off
  task automatic t_inactive();
    @(posedge ref_clk);
    deviceActive <= 1'b0;
    extOe <= 8'hC0;
    wr(OFF_OUTPUT_VALUE, 8'h00);
    rd(OFF_OUTPUT_VALUE, 8'h00, "blockedOut");
    rd(OFF_INPUT_LEVEL, 8'h00, "blockedIn");
    chk("padHold", 8'h3E, {2'b00, padOut});
    @(posedge ref_clk);
    deviceActive <= 1'b1;
    rd(OFF_OUTPUT_VALUE, 8'h3E, "keptOut");
  endtask
  // index fields, reserved port, wrong bank, unmapped offset
  task automatic t_misc();
    wr(OFF_PIN_INDEX, 8'hFF);
    rd(OFF_PIN_INDEX, 8'h17, "indexRsv");
    rd(OFF_PIN_SETUP, 8'h00, "reservedPort");
    @(posedge ref_clk);
    regBank <= 2'h0;
    rd(OFF_PIN_INDEX, 8'h00, "wrongBank");
    @(posedge ref_clk);
    regBank <= 2'h3;
    rd(5'h05, 8'h00, "unmapped");
  endtask
  // lock, software reset and power-up reset
  task automatic t_lock();
    wr(OFF_OUTPUT_VALUE, 8'h00);
    setp(8'h01, 8'h4F);
    wr(OFF_OUTPUT_VALUE, 8'h3F);
    rd(OFF_OUTPUT_VALUE, 8'h3D, "lockedOut");
    wr(OFF_PIN_SETUP, 8'h70);
    rd(OFF_PIN_SETUP, 8'h7F, "lockedSetup");
    setp(8'h06, 8'hFF);
    rd(OFF_PIN_SETUP, 8'h70, "inputOnlySetup");
    wr(OFF_OUTPUT_VALUE, 8'h00);
    @(posedge ref_clk);
    swReset <= 1'b1;
    @(posedge ref_clk);
    swReset <= 1'b0;
    rd(OFF_OUTPUT_VALUE, 8'h3D, "swResetOut");
    rd(OFF_PIN_INDEX, 8'h00, "swResetIndex");
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wr(OFF_PIN_INDEX, 8'h01);
    rd(OFF_PIN_SETUP, 8'h44, "lockCleared");
    rd(OFF_OUTPUT_VALUE, 8'h3F, "powerUpOut");
  endtask
  // one event on pin 6: delay to the event and cycles it stays up
  task automatic ev(input logic [7:0] cfg, output int n, output int w);
    setp(8'h06, cfg);
    @(posedge ref_clk);
    extVal[6] <= ~cfg[5];
    repeat (30) @(posedge ref_clk);
    extVal[6] <= cfg[5];
    w = 0;
    for (n = 0; n < 40 && pinEvent[6] !== 1'b1; n++)
      @(negedge ref_clk);
    if (n == 40)
      timeout("pinEvent");
    for (w = 0; w < 12 && pinEvent[6] === 1'b1; w++)
      @(negedge ref_clk);
  endtask
  // every event kind, then bounce and release with debounce on
  task automatic t_events();
    logic [7:0] cfgs [5] = '{8'h00, 8'h20, 8'h30, 8'h10, 8'h70};
    int k, n, w, d;
    for (k = 0; k < 5; k++)
    begin
      ev(cfgs[k], n, w);
      d = cfgs[k][6] ? DB : 0;
      chk("evWidth", cfgs[k][4] ? 8'h0C : 8'h01, w[7:0]);
      chk("evDelay", 8'h01, {7'h00, n >= 3 + d && n <= 7 + d});
    end
    @(posedge ref_clk);
    extVal[6] <= 1'b0;
    repeat (3) @(posedge ref_clk);
    extVal[6] <= 1'b1;
    w = 0;
    repeat (20)
    begin
      @(negedge ref_clk);
      w = w + (pinEvent[6] === 1'b1 ? 0 : 1);
    end
    chk("bounceIgnored", 8'h00, w[7:0]);
    @(posedge ref_clk);
    extVal[6] <= 1'b0;
    for (n = 0; n < 40 && pinEvent[6] !== 1'b0; n++)
      @(negedge ref_clk);
    if (n == 40)
      timeout("eventRelease");
    chk("releaseDelay", 8'h01, {7'h00, n >= DB && n <= DB + 7});
    chk("otherEvents", 8'h00, pinEvent & 8'hBF);
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_drive();
    t_inactive();
    t_misc();
    t_lock();
    t_events();
    complete_run();
  end
endmodule // testbench
